//--- hdl/hf_osc_pkg.sv
// Constants for the high-frequency oscillator control register
package hf_osc_pkg;
  localparam logic [7:0] OSC_CTRL_ADDR    = 8'hb2;
  localparam logic [7:0] OSC_CTRL_RESET   = 8'hc0;
  localparam int         ENABLE_BIT       = 7;
  localparam int         READY_BIT        = 6;
  localparam int         SUSPEND_BIT      = 5;
  localparam int         SYNC_BIT         = 4;
  localparam int         DIV_LSB          = 0;
  localparam int         DIV_WIDTH        = 2;
  localparam logic [2:0] SYSCLK_SEL_DIV   = 3'h0;
  localparam logic [2:0] SYSCLK_SEL_DIRECT = 3'h3;
  localparam logic [1:0] WAKE_SYNC_CLOCKS = 2'h3;
  localparam int         CLK_PERIOD_PS    = 5000;
  localparam int         SETTLE_NS        = 20;
  localparam int         SETTLE_CYCLES    = (SETTLE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
endpackage

//--- hdl/hf_clock_divider.sv
// Divider producing the scaled oscillator clock enable
`timescale 1ns/1ps
`default_nettype none
module hf_clock_divider
  import hf_osc_pkg::*;
(
  input  wire logic                 clk,
  input  wire logic                 reset,
  input  wire logic [DIV_WIDTH-1:0] ratio_sel,
  output logic                      tick_q
);
  typedef struct packed {
    logic [3:0] cnt;
    logic       tick;
  } div_s;

  div_s state_q;
  div_s state_d;

  // Field 0 -> 16, 1 -> 8, 2 -> 4, 3 -> 2; reload value is ratio minus one
  function automatic logic [3:0] reload(input logic [DIV_WIDTH-1:0] sel);
    reload = 4'hf >> sel;
  endfunction

  always_comb begin
    state_d      = state_q;
    state_d.tick = (state_q.cnt == 4'h0);
    // New ratio is picked up at wrap to keep the output glitch free
    if (state_q.cnt == 4'h0) begin
      state_d.cnt = reload(ratio_sel);
    end else begin
      state_d.cnt = state_q.cnt - 4'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      state_q <= '{cnt: 4'hf, tick: 1'b0};
    end else begin
      state_q <= state_d;
    end
  end

  assign tick_q = state_q.tick;

  AST_DIV_BY_TWO: assert property (@(posedge clk) disable iff (reset)
    (tick_q && ratio_sel == 2'h3 && $past(ratio_sel) == 2'h3) |=> !tick_q ##1 tick_q)
    else $error("divide by two spacing wrong");

  AST_DIV_BY_FOUR: assert property (@(posedge clk) disable iff (reset)
    (tick_q && ratio_sel == 2'h2 && $past(ratio_sel) == 2'h2) |=> !tick_q [*3] ##1 tick_q)
    else $error("divide by four spacing wrong");
endmodule
`default_nettype wire

//--- hdl/hf_oscillator_control.sv
// High-frequency oscillator control register, suspend and wake logic
`timescale 1ns/1ps
`default_nettype none
module hf_oscillator_control
  import hf_osc_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       reset,
  input  wire logic [7:0] sfr_addr,
  input  wire logic       sfr_wr,
  input  wire logic       sfr_rd,
  input  wire logic [7:0] sfr_wdata,
  output logic      [7:0] sfr_rdata,
  input  wire logic [2:0] sysclk_source_sel,
  input  wire logic       port0_match,
  input  wire logic       port1_match,
  input  wire logic       cmp0_enable,
  input  wire logic       cmp0_out,
  input  wire logic       timer3_overflow,
  input  wire logic       wake_timer_clk_pin,
  output logic            osc_run,
  output logic            sysclk_tick,
  output logic            core_stall
);
  typedef struct packed {
    logic                 enable;
    logic                 suspend;
    logic [DIV_WIDTH-1:0] div_sel;
    logic [3:0]           settle_cnt;
    logic                 ready;
    logic                 pending;
    logic [1:0]           tclk_cnt;
    logic                 cmp_s1;
    logic                 cmp_s2;
    logic                 tclk_s1;
    logic                 tclk_s2;
    logic                 tclk_s3;
    logic [7:0]           rdata;
    logic                 sys_tick;
    logic                 stall;
    logic                 run;
  } ctrl_s;

  ctrl_s state_q;
  ctrl_s state_d;

  logic div_tick;
  logic ctrl_hit;
  logic ctrl_wr;
  logic wake_other;
  logic wake_any;
  logic tclk_edge;
  logic internal_src;

  hf_clock_divider u_div (
    .clk      (clk),
    .reset    (reset),
    .ratio_sel(state_q.div_sel),
    .tick_q   (div_tick)
  );

  function automatic logic uses_internal(input logic [2:0] sel);
    uses_internal = (sel == SYSCLK_SEL_DIV) || (sel == SYSCLK_SEL_DIRECT);
  endfunction

  assign ctrl_hit     = (sfr_addr == OSC_CTRL_ADDR);
  assign ctrl_wr      = sfr_wr && ctrl_hit;
  assign internal_src = uses_internal(sysclk_source_sel);
  // Comparator output is analog, so only its synchronised copy is used
  assign wake_other   = port0_match || port1_match || (cmp0_enable && !state_q.cmp_s2);
  assign wake_any     = wake_other || timer3_overflow;
  assign tclk_edge    = state_q.tclk_s2 && !state_q.tclk_s3;

  always_comb begin
    state_d         = state_q;
    state_d.cmp_s1  = cmp0_out;
    state_d.cmp_s2  = state_q.cmp_s1;
    state_d.tclk_s1 = wake_timer_clk_pin;
    state_d.tclk_s2 = state_q.tclk_s1;
    state_d.tclk_s3 = state_q.tclk_s2;

    if (ctrl_wr) begin
      state_d.enable  = sfr_wdata[ENABLE_BIT];
      state_d.div_sel = sfr_wdata[DIV_LSB +: DIV_WIDTH];
      // A wake event in the write cycle wins, so it is never lost
      if (sfr_wdata[SUSPEND_BIT] && !wake_any) begin
        state_d.suspend = 1'b1;
      end
    end
    if (state_q.suspend && wake_any) begin
      state_d.suspend = 1'b0;
    end
    if (!state_d.enable) begin
      state_d.suspend = 1'b0;
    end

    // Restart or re-enable reloads the settling count
    if (!state_q.enable || state_q.suspend) begin
      state_d.settle_cnt = SETTLE_CYCLES[3:0];
    end else if (state_q.settle_cnt != 4'h0) begin
      state_d.settle_cnt = state_q.settle_cnt - 4'h1;
    end
    state_d.ready = state_d.enable && !state_d.suspend
                    && (state_q.settle_cnt == 4'h0) && state_q.enable && !state_q.suspend;

    // Timer domain needs a few of its own clocks to catch up after foreign wakes
    if (state_q.suspend && wake_other && !timer3_overflow) begin
      state_d.pending  = 1'b1;
      state_d.tclk_cnt = 2'h0;
    end else if (state_q.pending && tclk_edge) begin
      if (state_q.tclk_cnt == WAKE_SYNC_CLOCKS - 2'h1) begin
        state_d.pending = 1'b0;
      end
      state_d.tclk_cnt = state_q.tclk_cnt + 2'h1;
    end

    state_d.rdata = 8'h00;
    if (sfr_rd && ctrl_hit) begin
      state_d.rdata[ENABLE_BIT]              = state_q.enable;
      state_d.rdata[READY_BIT]               = state_q.ready;
      state_d.rdata[SUSPEND_BIT]             = state_q.suspend;
      state_d.rdata[SYNC_BIT]                = state_q.pending;
      state_d.rdata[DIV_LSB +: DIV_WIDTH]    = state_q.div_sel;
    end

    state_d.run   = state_d.enable && !state_d.suspend;
    // Stall holds the fetch so execution resumes at the next instruction
    state_d.stall = state_d.suspend && internal_src;
    if (state_d.suspend || !state_d.enable) begin
      state_d.sys_tick = !internal_src;
    end else if (sysclk_source_sel == SYSCLK_SEL_DIV) begin
      state_d.sys_tick = div_tick;
    end else begin
      state_d.sys_tick = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      state_q            <= '0;
      state_q.enable     <= OSC_CTRL_RESET[ENABLE_BIT];
      state_q.ready      <= OSC_CTRL_RESET[READY_BIT];
      state_q.suspend    <= OSC_CTRL_RESET[SUSPEND_BIT];
      state_q.div_sel    <= OSC_CTRL_RESET[DIV_LSB +: DIV_WIDTH];
      state_q.run        <= OSC_CTRL_RESET[ENABLE_BIT];
      // Comparator idles high; a low reset value would fake a wake
      state_q.cmp_s1     <= 1'b1;
      state_q.cmp_s2     <= 1'b1;
    end else begin
      state_q <= state_d;
    end
  end

  assign sfr_rdata   = state_q.rdata;
  assign osc_run     = state_q.run;
  assign sysclk_tick = state_q.sys_tick;
  assign core_stall  = state_q.stall;

  sequence wr_ctrl_s(logic [7:0] mask, logic [7:0] val);
    sfr_wr && ctrl_hit && ((sfr_wdata & mask) == val);
  endsequence

  sequence foreign_wake_s;
    state_q.suspend && wake_other && !timer3_overflow;
  endsequence

  AST_ENABLE_WRITE: assert property (@(posedge clk) disable iff (reset)
    wr_ctrl_s(8'h80, 8'h00) |=> !state_q.enable && !osc_run)
    else $error("disable write not honoured");

  AST_READY_LOW: assert property (@(posedge clk) disable iff (reset)
    (!state_q.enable || state_q.suspend) |=> !state_q.ready [*2])
    else $error("ready set while stopped");

  AST_READY_RETURNS: assert property (@(posedge clk) disable iff (reset)
    ($fell(state_q.suspend) && state_q.enable && !sfr_wr) ##1 (state_q.enable && !state_q.suspend) [*6]
    |-> state_q.ready)
    else $error("ready did not return after settling");

  AST_SUSPEND_ENTER: assert property (@(posedge clk) disable iff (reset)
    wr_ctrl_s(8'ha0, 8'ha0) ##0 !wake_any |=> state_q.suspend && !osc_run)
    else $error("suspend not entered");

  AST_WAKE: assert property (@(posedge clk) disable iff (reset)
    (state_q.suspend && wake_any) |=> !state_q.suspend && (osc_run == state_q.enable))
    else $error("wake event missed");

  AST_SYNC_SET: assert property (@(posedge clk) disable iff (reset)
    foreign_wake_s |=> state_q.pending ##1 (sfr_rdata[SYNC_BIT] || !$past(sfr_rd && ctrl_hit)))
    else $error("sync flag not raised");

  AST_SYNC_CLEAR: assert property (@(posedge clk) disable iff (reset)
    (state_q.pending && tclk_edge && state_q.tclk_cnt == 2'h2
     && !(state_q.suspend && wake_other && !timer3_overflow))
    |=> !state_q.pending)
    else $error("sync flag held too long");

  AST_RESERVED_ZERO: assert property (@(posedge clk) disable iff (reset)
    1'b1 |-> sfr_rdata[3:2] == 2'h0)
    else $error("reserved bits not zero");

  AST_OTHER_SOURCE: assert property (@(posedge clk) disable iff (reset)
    (!internal_src && !state_q.suspend && state_q.enable && $stable(sysclk_source_sel))
    ##1 !state_q.suspend |-> sysclk_tick)
    else $error("divider affected foreign source");

  AST_STALL_RELEASE: assert property (@(posedge clk) disable iff (reset)
    $fell(core_stall) |-> $past(wake_any) || !$past(internal_src) || !state_q.enable
    || $past(!state_d.enable))
    else $error("stall released without cause");

  AST_TICK_STOPPED: assert property (@(posedge clk) disable iff (reset)
    (state_q.suspend && $past(internal_src)) |-> !sysclk_tick)
    else $error("system tick ran while suspended");

  AST_SYNC_HOLD: assert property (@(posedge clk) disable iff (reset)
    (state_q.pending && !tclk_edge) |=> state_q.pending)
    else $error("sync flag dropped without timer clock");

  AST_DIV_WRITE: assert property (@(posedge clk) disable iff (reset)
    wr_ctrl_s(8'h00, 8'h00) |=> state_q.div_sel == $past(sfr_wdata[DIV_LSB +: DIV_WIDTH]))
    else $error("divider field not written");

  AST_STALL_TRACKS: assert property (@(posedge clk) disable iff (reset)
    1'b1 |-> core_stall == (state_q.suspend && $past(internal_src)))
    else $error("stall does not follow suspend");
endmodule
`default_nettype wire

//--- verification/hf_oscillator_control_test.sv
// Self-checking bench for the oscillator control register
`timescale 1ns/1ps
`default_nettype none
module hf_oscillator_control_test
  import hf_osc_pkg::*;
;
  logic       clk       = 1'b0;
  logic       reset     = 1'b1;
  logic       sfr_wr    = 1'b0;
  logic       sfr_rd    = 1'b0;
  logic [7:0] sfr_addr  = 8'h00;
  logic [7:0] sfr_wdata = 8'h00;
  logic [2:0] src       = 3'h0;
  logic       p0        = 1'b0;
  logic       p1        = 1'b0;
  logic       c_en      = 1'b0;
  logic       c_out     = 1'b1;
  logic       t3        = 1'b0;
  logic       wtc       = 1'b0;
  logic [7:0] sfr_rdata;
  logic       osc_run;
  logic       sysclk_tick;
  logic       core_stall;
  int         num_errors = 0;
  int         n_checks   = 0;
  int         seed       = 66384;

  always #2.5 clk = ~clk;

  hf_oscillator_control dut_u (
    .clk(clk), .reset(reset), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
    .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .sysclk_source_sel(src),
    .port0_match(p0), .port1_match(p1), .cmp0_enable(c_en), .cmp0_out(c_out),
    .timer3_overflow(t3), .wake_timer_clk_pin(wtc), .osc_run(osc_run),
    .sysclk_tick(sysclk_tick), .core_stall(core_stall)
  );

  task automatic wrap_up();
    if (num_errors == 0 && n_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic cmp8(input logic [7:0] g, input logic [7:0] e);
    n_checks++;
    if (g !== e) begin
      num_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task automatic cmp1(input logic g, input logic e);
    n_checks++;
    if (g !== e) begin
      num_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    sfr_addr  = a;
    sfr_wdata = d;
    sfr_wr    = 1'b1;
    @(negedge clk);
    sfr_wr = 1'b0;
  endtask

  // Read data stands one cycle only, so it is taken at the very next falling edge
  task automatic chk(input logic [7:0] a, input logic [7:0] e);
    @(negedge clk);
    sfr_addr = a;
    sfr_rd   = 1'b1;
    @(negedge clk);
    sfr_rd = 1'b0;
    cmp8(sfr_rdata, e);
  endtask

  task automatic count_ticks(output logic [7:0] c);
    c = 8'h00;
    repeat (64) begin
      @(negedge clk);
      c = c + {7'h00, sysclk_tick};
    end
  endtask

  // Slow wake-timer clock so the two-flop sync sees every edge
  task automatic timer_clocks(input int k);
    repeat (k) begin
      wtc = 1'b1;
      repeat (4) @(negedge clk);
      wtc = 1'b0;
      repeat (4) @(negedge clk);
    end
  endtask

  function automatic logic [7:0] exp_ticks(input logic [1:0] dv);
    return 8'h04 << dv;
  endfunction

  initial begin
    logic [7:0] a;
    logic [7:0] cnt;
    int         n;
    repeat (16) @(negedge clk);
    reset = 1'b0;
    cmp8(sfr_rdata, 8'h00);
    chk(OSC_CTRL_ADDR, OSC_CTRL_RESET);
    cmp1(osc_run, 1'b1);
    wr(OSC_CTRL_ADDR, 8'h0f);
    chk(OSC_CTRL_ADDR, 8'h03);
    cmp1(osc_run, 1'b0);
    repeat (4) begin
      a = 8'($random(seed));
      if (a == OSC_CTRL_ADDR) a = 8'h00;
      wr(a, 8'($random(seed)));
      chk(a, 8'h00);
    end
    chk(OSC_CTRL_ADDR, 8'h03);
    for (int i = 0; i < 4; i++) begin
      wr(OSC_CTRL_ADDR, {6'h20, 2'(i)});
      repeat (40) @(negedge clk);
      chk(OSC_CTRL_ADDR, {6'h30, 2'(i)});
      count_ticks(cnt);
      cmp8(cnt, exp_ticks(2'(i)));
    end
    for (int s = 1; s < 8; s++) begin
      src = 3'(s);
      repeat (4) @(negedge clk);
      count_ticks(cnt);
      cmp8(cnt, 8'h40);
    end
    src = 3'h0;
    for (int k = 0; k < 4; k++) begin
      wr(OSC_CTRL_ADDR, 8'ha3);
      repeat (2) @(negedge clk);
      cmp1(osc_run, 1'b0);
      cmp1(core_stall, 1'b1);
      cmp1(sysclk_tick, 1'b0);
      chk(OSC_CTRL_ADDR, 8'ha3);
      // Low comparator output alone must not wake while the comparator is off
      c_out = 1'b0;
      repeat (8) @(negedge clk);
      cmp1(core_stall, 1'b1);
      case (k)
        0: p0 = 1'b1;
        1: p1 = 1'b1;
        2: c_en = 1'b1;
        default: t3 = 1'b1;
      endcase
      n = 0;
      while (osc_run !== 1'b1 && n < 20) begin
        @(negedge clk);
        n++;
      end
      {p0, p1, c_en, c_out, t3} = 5'h02;
      cmp1(osc_run, 1'b1);
      cmp1(core_stall, 1'b0);
      repeat (16) @(negedge clk);
      chk(OSC_CTRL_ADDR, (k == 3) ? 8'hc3 : 8'hd3);
      // Timer registers stay untouched until the sync flag drops
      timer_clocks(3);
      chk(OSC_CTRL_ADDR, 8'hc3);
    end
    wrap_up();
  end

  initial begin
    #100000;
    num_errors++;
    wrap_up();
  end
endmodule
`default_nettype wire
